// File: csc_pkg.sv
package csc_pkg;

  // register indices; byte address is four times the index
  localparam logic [11:0] CTRL_IDX    = 12'hfe9;
  localparam logic [11:0] DATA_IDX    = 12'hfea;
  localparam logic [11:0] IRQ_STS_IDX = 12'hfeb;
  localparam logic [11:0] IRQ_MSK_IDX = 12'hfec;

  // control field positions
  localparam int CTRL_EN_BIT  = 0;
  localparam int CTRL_WIN_LSB = 1;
  localparam int CTRL_WIN_MSB = 3;
  localparam int CTRL_SRC_BIT = 4;

  // interrupt event bits
  localparam int EVT_DONE_BIT  = 0;
  localparam int EVT_SAT_BIT   = 1;
  localparam int EVT_STALL_BIT = 2;
  localparam int EVT_W         = 3;

  // reset values and the count saturation value
  localparam logic [7:0]       CTRL_RST  = 8'h00;
  localparam logic [7:0]       DATA_RST  = 8'h00;
  localparam logic [EVT_W-1:0] IRQ_RST   = 3'h0;
  localparam logic [7:0]       CNT_SAT   = 8'hff;

  // widths
  localparam int CNT_W  = 8;
  localparam int TAP_N  = 8;
  localparam int SYNC_N = TAP_N + 2;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef struct packed {
    logic       src;
    logic [2:0] win;
    logic       en;
  } csc_ctrl_t;

  typedef struct packed {
    logic        vld;
    logic        wr;
    logic [11:0] idx;
  } csc_dphase_t;

  typedef enum logic [1:0] {
    CSC_IDLE,
    CSC_ARM,
    CSC_COUNT,
    CSC_STALL
  } csc_state_t;

endpackage

// File: csc_counter.sv
// Register access over AHB-Lite is this design's own decision.
module csc_counter (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        main_osc_clk,
  input  wire logic        sub_osc_clk,
  input  wire logic [7:0]  tbt_taps,
  input  wire logic        tbt_run,
  output logic             irq
);

  logic [csc_pkg::SYNC_N-1:0] s1_q;
  logic [csc_pkg::SYNC_N-1:0] s2_q;
  logic                       osc_q;
  logic [csc_pkg::TAP_N-1:0]  tap_q;
  logic                       run1_q;
  logic                       run2_q;
  csc_pkg::csc_dphase_t       dph_q;
  csc_pkg::csc_ctrl_t         ctrl_q;
  csc_pkg::csc_state_t        state_q;
  logic [7:0]                 cnt_q;
  logic [7:0]                 result_q;
  logic                       osc_seen_q;
  logic [csc_pkg::EVT_W-1:0]  sts_q;
  logic [csc_pkg::EVT_W-1:0]  msk_q;

  logic osc_s;
  logic tap_s;
  logic osc_rise;
  logic tap_rise;
  logic tap_fall;
  logic run;
  logic wr_ctrl;
  logic en_set;
  logic en_clr;
  logic hw_done;
  logic hw_stall;
  logic stall_go;
  logic cnt_inc;
  logic [csc_pkg::EVT_W-1:0] evt;
  logic [csc_pkg::EVT_W-1:0] sts_clr;

  // two-stage synchronisers for taps and both oscillators
  genvar gi;
  generate
    for (gi = 0; gi < csc_pkg::SYNC_N; gi++) begin : g_sync
      logic pin;
      if (gi < csc_pkg::TAP_N) begin : g_tap
        assign pin = tbt_taps[gi];
      end else if (gi == csc_pkg::TAP_N) begin : g_main
        assign pin = main_osc_clk;
      end else begin : g_sub
        assign pin = sub_osc_clk;
      end
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          s1_q[gi] <= 1'b0;
          s2_q[gi] <= 1'b0;
        end else begin
          s1_q[gi] <= pin;
          s2_q[gi] <= s1_q[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run1_q <= 1'b0;
      run2_q <= 1'b0;
    end else begin
      run1_q <= tbt_run;
      run2_q <= run1_q;
    end
  end

  // oscillator must be slower than half of hclk to be counted
  assign osc_s = ctrl_q.src ? s2_q[csc_pkg::TAP_N+1] : s2_q[csc_pkg::TAP_N];
  assign tap_s = s2_q[ctrl_q.win];
  assign run   = run2_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_q <= 1'b0;
      tap_q <= '0;
    end else begin
      osc_q <= osc_s;
      tap_q <= s2_q[csc_pkg::TAP_N-1:0];
    end
  end

  // each tap keeps its own history, so arming with a new window fakes no edge
  assign osc_rise = osc_s & ~osc_q;
  assign tap_rise = run & tap_s & ~tap_q[ctrl_q.win];
  assign tap_fall = run & ~tap_s & tap_q[ctrl_q.win];

  // bus slave: zero wait, always okay
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_q <= '0;
    end else if (hready) begin
      dph_q.vld <= hsel & (htrans == csc_pkg::HTRANS_NONSEQ) & (haddr[31:14] == 18'h0)
                   & (haddr[1:0] == 2'h0);
      dph_q.wr  <= hwrite;
      dph_q.idx <= haddr[13:2];
    end
  end

  always_comb begin
    hrdata = 32'h0;
    if (dph_q.vld && !dph_q.wr) begin
      if (dph_q.idx == csc_pkg::CTRL_IDX) begin
        hrdata[4:0] = ctrl_q;
      end else if (dph_q.idx == csc_pkg::DATA_IDX) begin
        hrdata[7:0] = ctrl_q.en ? 8'h00 : result_q;
      end else if (dph_q.idx == csc_pkg::IRQ_STS_IDX) begin
        hrdata[csc_pkg::EVT_W-1:0] = sts_q;
      end else if (dph_q.idx == csc_pkg::IRQ_MSK_IDX) begin
        hrdata[csc_pkg::EVT_W-1:0] = msk_q;
      end
    end
  end

  // data register has no write path at all
  assign wr_ctrl  = dph_q.vld & dph_q.wr & (dph_q.idx == csc_pkg::CTRL_IDX);
  assign en_set   = wr_ctrl & hwdata[csc_pkg::CTRL_EN_BIT] & ~ctrl_q.en;
  assign en_clr   = wr_ctrl & ~hwdata[csc_pkg::CTRL_EN_BIT] & ctrl_q.en;
  assign hw_done  = (state_q == csc_pkg::CSC_COUNT) & tap_rise & osc_seen_q;
  assign stall_go = (state_q == csc_pkg::CSC_COUNT) & tap_rise & ~osc_seen_q;
  assign hw_stall = (state_q == csc_pkg::CSC_STALL) & tap_fall;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= csc_pkg::CTRL_RST[4:0];
    end else if (wr_ctrl) begin
      ctrl_q.src <= hwdata[csc_pkg::CTRL_SRC_BIT];
      ctrl_q.win <= hwdata[csc_pkg::CTRL_WIN_MSB:csc_pkg::CTRL_WIN_LSB];
      ctrl_q.en  <= (en_set | en_clr) ? hwdata[csc_pkg::CTRL_EN_BIT]
                                      : (ctrl_q.en & ~hw_done & ~hw_stall);
    end else if (hw_done || hw_stall) begin
      ctrl_q.en <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= csc_pkg::CSC_IDLE;
    end else if (en_set) begin
      state_q <= csc_pkg::CSC_ARM;
    end else if (en_clr) begin
      state_q <= csc_pkg::CSC_IDLE;
    end else begin
      case (state_q)
        csc_pkg::CSC_ARM: begin
          if (tap_rise) begin
            state_q <= csc_pkg::CSC_COUNT;
          end
        end
        csc_pkg::CSC_COUNT: begin
          if (hw_done) begin
            state_q <= csc_pkg::CSC_IDLE;
          end else if (stall_go) begin
            state_q <= csc_pkg::CSC_STALL;
          end
        end
        csc_pkg::CSC_STALL: begin
          if (hw_stall) begin
            state_q <= csc_pkg::CSC_IDLE;
          end
        end
        default: state_q <= csc_pkg::CSC_IDLE;
      endcase
    end
  end

  // activity since the last tap fall tells a live clock from a dead one
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_seen_q <= 1'b0;
    end else if (state_q != csc_pkg::CSC_COUNT || tap_fall) begin
      osc_seen_q <= 1'b0;
    end else if (osc_rise && run) begin
      osc_seen_q <= 1'b1;
    end
  end

  // an edge coinciding with the closing tap edge is not counted
  assign cnt_inc = run & (state_q == csc_pkg::CSC_COUNT) & osc_rise & ~tap_rise
                   & (cnt_q != csc_pkg::CNT_SAT);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= csc_pkg::DATA_RST;
    end else if (en_set || en_clr || hw_stall) begin
      cnt_q <= 8'h00;
    end else if (cnt_inc) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      result_q <= csc_pkg::DATA_RST;
    end else if (en_set || en_clr || hw_stall) begin
      result_q <= 8'h00;
    end else if (hw_done) begin
      result_q <= cnt_q;
    end
  end

  // interrupt events: set wins over write-one-to-clear
  assign evt[csc_pkg::EVT_DONE_BIT]  = hw_done;
  assign evt[csc_pkg::EVT_SAT_BIT]   = hw_done & (cnt_q == csc_pkg::CNT_SAT);
  assign evt[csc_pkg::EVT_STALL_BIT] = hw_stall;
  assign sts_clr = (dph_q.vld && dph_q.wr && dph_q.idx == csc_pkg::IRQ_STS_IDX)
                   ? hwdata[csc_pkg::EVT_W-1:0] : '0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sts_q <= csc_pkg::IRQ_RST;
    end else begin
      sts_q <= (sts_q & ~sts_clr) | evt;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      msk_q <= csc_pkg::IRQ_RST;
    end else if (dph_q.vld && dph_q.wr && dph_q.idx == csc_pkg::IRQ_MSK_IDX) begin
      msk_q <= hwdata[csc_pkg::EVT_W-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |((sts_q & ~sts_clr | evt) & msk_q);
    end
  end

  // checks
  sequence s_arm_wr;
    wr_ctrl && hwdata[0] && !ctrl_q.en;
  endsequence

  sequence s_win_close;
    state_q == csc_pkg::CSC_COUNT && tap_rise && osc_seen_q;
  endsequence

  AST_READ_ZERO: assert property (@(posedge hclk) disable iff (!hresetn)
    dph_q.vld && !dph_q.wr && dph_q.idx == csc_pkg::DATA_IDX && ctrl_q.en
    |-> hrdata == 32'h0)
    else $error("count visible while enabled");

  AST_CTRL_HI_ZERO: assert property (@(posedge hclk) disable iff (!hresetn)
    dph_q.vld && !dph_q.wr && dph_q.idx == csc_pkg::CTRL_IDX |-> hrdata[31:5] == 27'h0)
    else $error("control upper bits not zero");

  AST_ARM_CLEARS: assert property (@(posedge hclk) disable iff (!hresetn)
    s_arm_wr |=> result_q == 8'h00 && cnt_q == 8'h00 && state_q == csc_pkg::CSC_ARM
    && ctrl_q.en)
    else $error("arm did not clear and arm");

  AST_STOP_WR: assert property (@(posedge hclk) disable iff (!hresetn)
    en_clr |=> !ctrl_q.en && result_q == 8'h00 && state_q == csc_pkg::CSC_IDLE)
    else $error("enable clear did not stop");

  AST_START: assert property (@(posedge hclk) disable iff (!hresetn)
    state_q == csc_pkg::CSC_ARM && tap_rise && !wr_ctrl |=> state_q == csc_pkg::CSC_COUNT)
    else $error("count did not start on tap rise");

  AST_AUTO_STOP: assert property (@(posedge hclk) disable iff (!hresetn)
    s_win_close ##0 !wr_ctrl |=> !ctrl_q.en && result_q == $past(cnt_q))
    else $error("window close did not stop and latch");

  AST_INC: assert property (@(posedge hclk) disable iff (!hresetn)
    cnt_inc && !wr_ctrl |=> cnt_q == $past(cnt_q) + 8'h01)
    else $error("count missed an edge");

  AST_SAT: assert property (@(posedge hclk) disable iff (!hresetn)
    cnt_q == 8'hff && !wr_ctrl && !hw_stall |=> cnt_q == 8'hff)
    else $error("counter wrapped");

  AST_HALT: assert property (@(posedge hclk) disable iff (!hresetn)
    !run && !wr_ctrl |=> $stable(cnt_q) && $stable(state_q))
    else $error("count moved while timer halted");

  AST_STALL_CLR: assert property (@(posedge hclk) disable iff (!hresetn)
    hw_stall && !wr_ctrl |=> !ctrl_q.en && cnt_q == 8'h00 && result_q == 8'h00)
    else $error("stalled clock not cleared at tap fall");

endmodule

// File: csc_osc_model.sv
module csc_osc_model #(
  parameter int H_MAIN = 2,
  parameter int H_SUB  = 3
) (
  input  wire logic hclk,
  input  wire logic main_on,
  output logic      main_osc_clk,
  output logic      sub_osc_clk
);
  timeunit 1ns;
  timeprecision 1ps;
  int t = 0;
  initial begin
    main_osc_clk = 1'b0;
    sub_osc_clk  = 1'b0;
  end
  // first toggle is a rise and rises land on odd cycles, never on a tap rise
  always @(posedge hclk) begin
    t <= t + 1;
    if (!main_on) begin
      main_osc_clk <= 1'b0;
    end else if (t % H_MAIN == 0) begin
      main_osc_clk <= ~main_osc_clk;
    end
    if (t % H_SUB == 0) begin
      sub_osc_clk <= ~sub_osc_clk;
    end
  end
endmodule

// File: tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] A_CTL = {18'h0, csc_pkg::CTRL_IDX, 2'h0};
  localparam logic [31:0] A_DAT = {18'h0, csc_pkg::DATA_IDX, 2'h0};
  localparam logic [31:0] A_STS = {18'h0, csc_pkg::IRQ_STS_IDX, 2'h0};
  localparam logic [31:0] A_MSK = {18'h0, csc_pkg::IRQ_MSK_IDX, 2'h0};
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, main_on = 1'b1;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd_s;
  logic [1:0]  htrans = 2'h0;
  logic        hreadyout, irq, rdy_s, main_osc_clk, sub_osc_clk;
  logic        hresp, run_on = 1'b1;
  logic [15:0] cnt = 16'h0;
  logic [2:0]  msk;
  wire  [7:0]  taps;
  int          fails = 0, tests_run = 0, seed = 95, m_cnt, m_win;
  bit          m_on, m_run, m_src, tp_q, op_q;
  // taps run far faster than a real time base so the widest window fits the run
  assign taps = cnt[9:2];
  csc_counter csc_counter_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .main_osc_clk(main_osc_clk),
    .sub_osc_clk(sub_osc_clk), .tbt_taps(taps), .tbt_run(run_on), .irq(irq));
  csc_osc_model csc_osc_model_inst (
    .hclk(hclk), .main_on(main_on), .main_osc_clk(main_osc_clk), .sub_osc_clk(sub_osc_clk));
  initial forever #2 hclk = ~hclk;
  always @(posedge hclk) begin
    cnt   <= cnt + 16'h1;
    rd_s  <= hrdata;
    rdy_s <= hreadyout;
  end
  // reference count: rises of the chosen clock between two tap rises, held at 255
  always @(posedge hclk) begin
    if (m_on && run_on && taps[m_win] && !tp_q) begin
      m_on  = !m_run;
      m_run = !m_run;
    end else if (m_run && run_on && (m_src ? sub_osc_clk : main_osc_clk) && !op_q
                 && m_cnt < 255) begin
      m_cnt++;
    end
    tp_q = taps[m_win];
    op_q = m_src ? sub_osc_clk : main_osc_clk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wt;
    do begin
      @(posedge hclk);
      #1;
    end while (rdy_s !== 1'b1);
  endtask
  task automatic bus(input bit wr, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    wt();
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= d;
    wt();
    r = rd_s;
    chk(32'(hresp), 32'h0);
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rdc(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask
  task automatic meas(input logic [2:0] w, input bit s, input bit stop);
    logic [31:0] r;
    logic [2:0]  st;
    int          n;
    m_on  = 0;
    m_win = w;
    m_src = s;
    m_cnt = 0;
    m_run = 0;
    msk   = w[2] ? 3'h7 : 3'h0;
    wr(A_MSK, 32'(msk));
    @(negedge taps[w]);
    wr(A_CTL, {27'h0, s, w, 1'b1});
    m_on = 1;
    rdc(A_DAT, 32'h0);
    if (stop) begin
      @(posedge taps[w]);
      repeat (8) @(posedge hclk);
      main_on <= 1'b0;
    end
    n = 0;
    do begin
      bus(1'b0, A_CTL, 32'h0, r);
      n++;
    end while (r[0] !== 1'b0 && n < 3000);
    chk(r, {27'h0, s, w, 1'b0});
    if (stop) m_cnt = 0;
    st = stop ? 3'h4 : {1'b0, m_cnt == 255, 1'b1};
    rdc(A_DAT, 32'(m_cnt));
    rdc(A_STS, 32'(st));
    chk(32'(irq), 32'(|(st & msk)));
    wr(A_STS, 32'h7);
    rdc(A_STS, 32'h0);
    chk(32'(irq), 32'h0);
    main_on <= 1'b1;
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge hclk);
    fails++;
    report_and_stop();
  end
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rdc(A_CTL, 32'h0);
    rdc(A_DAT, 32'h0);
    rdc(A_STS, 32'h0);
    rdc(A_MSK, 32'h0);
    wr(A_CTL, 32'hce);
    rdc(A_CTL, 32'he);
    wr(A_CTL, 32'h0);
    wr(A_DAT, $random(seed));
    rdc(A_DAT, 32'h0);
    wr(A_MSK + 32'h4, $random(seed));
    rdc(A_MSK + 32'h4, 32'h0);
    for (int w = 0; w < 8; w++) begin
      meas(3'(w), w[0] && w != 7, 1'b0);
    end
    // timer halted mid-window: the count pauses and the reference skips the same edges
    fork
      meas(3'h4, 1'b0, 1'b0);
      begin
        repeat (3) @(posedge hclk);
        @(negedge taps[4]);
        @(posedge taps[4]);
        repeat (20) @(posedge hclk);
        run_on <= 1'b0;
        repeat (40) @(posedge hclk);
        run_on <= 1'b1;
      end
    join
    meas(3'h3, 1'b0, 1'b1);
    wr(A_CTL, 32'h1f);
    @(posedge taps[7]);
    repeat (8 + ($unsigned($random(seed)) % 128)) @(posedge hclk);
    wr(A_CTL, 32'h1e);
    rdc(A_DAT, 32'h0);
    rdc(A_CTL, 32'h1e);
    rdc(A_STS, 32'h0);
    report_and_stop();
  end
endmodule
